// *** fnm_pkg.sv ***
// Constants, types and helper functions of the fault notice builder.
// Assumes a single clock domain; every user of this package imports it whole.
package fnm_pkg;
    localparam int NOTICE_W = 64;
    localparam int DETAIL_W = 40;
    localparam int SIZE_W = 16;
    localparam logic [15:0] CODE_NONE = 16'h0000;
    localparam logic [15:0] CODE_CFG_FAULT = 16'ha000;
    localparam logic [15:0] CODE_MAP_FAULT = 16'hff55;
    localparam logic [7:0] SUB_MAP_FAULT = 8'h01;
    localparam logic [7:0] SUM_NONE = 8'h00;
    localparam logic [7:0] SUM_LINK = 8'h10;
    localparam logic [7:0] SUM_OTHER = 8'h80;
    localparam logic [7:0] DET_OUT_LEN = 8'h08;
    localparam logic [7:0] DET_OUT_ADDR = 8'h09;
    localparam logic [7:0] DET_OUT_MODE = 8'h0a;
    localparam logic [7:0] DET_IN_LEN = 8'h0c;
    localparam logic [7:0] DET_IN_ADDR = 8'h0d;
    localparam logic [7:0] DET_IN_MODE = 8'h0e;
    localparam logic [15:0] CHAN_ADDR_MIN = 16'h1000;
    localparam logic [15:0] CHAN_ADDR_MAX = 16'h2fff;
    localparam logic [15:0] CHAN_ADDR_MAX_EVEN = 16'h2ffe;
    localparam logic [31:0] OUT_MODE_EXP = 32'h00010024;
    localparam logic [31:0] IN_MODE_EXP = 32'h00010322;
    localparam logic [7:0] MODE_CTRL_MASK = 8'h0f;
    localparam logic [7:0] MODE_ACT_MASK = 8'h01;
    localparam logic [15:0] MAP_SIZE_MAX = 16'h0020;
    localparam int REG_AW = 16;
    localparam int REG_DW = 32;
    localparam logic [15:0] ADDR_ERR_SUMMARY = 16'h1001;
    localparam logic [15:0] ADDR_ERR_CODE = 16'h2000;
    localparam logic [15:0] ADDR_STATUS = 16'h2004;
    localparam logic [15:0] ADDR_MASK = 16'h2008;
    localparam logic [15:0] ADDR_NOTICE_LO = 16'h200c;
    localparam logic [15:0] ADDR_NOTICE_HI = 16'h2010;
    localparam int ST_W = 3;
    localparam int ST_BUILT = 0;
    localparam int ST_DROPPED = 1;
    localparam int ST_CFG = 2;
    typedef enum logic [2:0]
    {
        FNM_EV_NONE = 3'b000,
        FNM_EV_RESET = 3'b001,
        FNM_EV_CHECK = 3'b010,
        FNM_EV_ALARM = 3'b011,
        FNM_EV_CLEAR = 3'b100
    } fnm_event_t;

    // Odd, below the window or above it
    function automatic logic fnm_addr_bad(input logic [15:0] addr);
        fnm_addr_bad = addr[0] || (addr < CHAN_ADDR_MIN) || (addr > CHAN_ADDR_MAX);
    endfunction

    // Inactive, single buffer or wrong direction
    function automatic logic fnm_mode_bad(input logic [7:0] ctrl, input logic [7:0] act,
                                          input logic [31:0] exp);
        fnm_mode_bad = ((ctrl & MODE_CTRL_MASK) != (exp[7:0] & MODE_CTRL_MASK))
                       || ((act & MODE_ACT_MASK) != (exp[23:16] & MODE_ACT_MASK));
    endfunction

    // Size low byte first, twice
    function automatic logic [31:0] fnm_size_bytes(input logic [15:0] size);
        fnm_size_bytes = {size, size};
    endfunction
endpackage

// *** fnm_chk_if.sv ***
// Carries the buffer channel settings to the checker and its verdict back.
// Assumes both ends run on the builder clock.
`timescale 1ns/100ps
interface fnm_chk_if;
    logic req;
    logic [15:0] out_addr;
    logic [15:0] out_len;
    logic [7:0] out_ctrl;
    logic [7:0] out_act;
    logic [15:0] in_addr;
    logic [15:0] in_len;
    logic [7:0] in_ctrl;
    logic [7:0] in_act;
    logic [15:0] rx_size;
    logic [15:0] tx_size;
    logic done;
    logic fault;
    logic map_fault;
    logic [39:0] detail;
    modport builder (output req, out_addr, out_len, out_ctrl, out_act, in_addr, in_len,
                     in_ctrl, in_act, rx_size, tx_size, input done, fault, map_fault, detail);
    modport check_side (input req, out_addr, out_len, out_ctrl, out_act, in_addr, in_len,
                     in_ctrl, in_act, rx_size, tx_size, output done, fault, map_fault, detail);
endinterface

// *** fnm_chan_check.sv ***
// Buffer channel checker for the pre-operational to safe-operational step.
// Assumes settings stand steady in the cycle of the request; verdict one cycle later.
`timescale 1ns/100ps
module fnm_chan_check
    import fnm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    fnm_chk_if.check_side chk
);
    logic done_reg;
    logic fault_reg;
    logic map_fault_reg;
    logic [39:0] detail_reg;
    logic fault_next;
    logic map_fault_next;
    logic [39:0] detail_next;
    logic [31:0] out_tail;
    logic [31:0] in_tail;

    always_comb
    begin
        out_tail = (chk.rx_size == 16'h0000) ? 32'h0 : fnm_size_bytes(chk.rx_size);
        in_tail = (chk.tx_size == 16'h0000) ? 32'h0 : fnm_size_bytes(chk.tx_size);
        fault_next = 1'b1;
        map_fault_next = 1'b0;
        detail_next = '0;
        if ((chk.rx_size > MAP_SIZE_MAX) || (chk.tx_size > MAP_SIZE_MAX))
        begin
            map_fault_next = 1'b1;
            detail_next = {32'h0, SUB_MAP_FAULT};
        end
        else if (chk.out_len != chk.rx_size)
            detail_next = {out_tail, DET_OUT_LEN};
        else if (fnm_addr_bad(chk.out_addr))
            detail_next = {(chk.rx_size == 16'h0000) ? 32'h0 :
                           {CHAN_ADDR_MAX_EVEN, CHAN_ADDR_MIN}, DET_OUT_ADDR};
        else if (fnm_mode_bad(chk.out_ctrl, chk.out_act, OUT_MODE_EXP))
            detail_next = {(chk.rx_size == 16'h0000) ? 32'h0 : OUT_MODE_EXP,
                           DET_OUT_MODE};
        else if (chk.in_len != chk.tx_size)
            detail_next = {in_tail, DET_IN_LEN};
        else if (fnm_addr_bad(chk.in_addr))
            detail_next = {(chk.tx_size == 16'h0000) ? 32'h0 :
                           {CHAN_ADDR_MAX_EVEN, CHAN_ADDR_MIN}, DET_IN_ADDR};
        else if (fnm_mode_bad(chk.in_ctrl, chk.in_act, IN_MODE_EXP))
            detail_next = {(chk.tx_size == 16'h0000) ? 32'h0 : IN_MODE_EXP,
                           DET_IN_MODE};
        else
            fault_next = 1'b0;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            done_reg <= 1'b0;
            fault_reg <= 1'b0;
            map_fault_reg <= 1'b0;
            detail_reg <= '0;
        end
        else
        begin
            done_reg <= chk.req;
            if (chk.req)
            begin
                fault_reg <= fault_next;
                map_fault_reg <= map_fault_next;
                detail_reg <= detail_next;
            end
        end
    end

    assign chk.done = done_reg;
    assign chk.fault = fault_reg;
    assign chk.map_fault = map_fault_reg;
    assign chk.detail = detail_reg;

    property p_out_len;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        chk.req && chk.rx_size == 16'h0009 && chk.tx_size <= MAP_SIZE_MAX && chk.out_len != 16'h0009
        |=> chk.done && chk.fault && chk.detail == 40'h0009000908;
    endproperty
    a_out_len: assert property (p_out_len) else $error("Length fault detail wrong");

    property p_map_big;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        chk.req && chk.rx_size > MAP_SIZE_MAX
        |=> chk.map_fault && chk.detail == {32'h0, SUB_MAP_FAULT};
    endproperty
    a_map_big: assert property (p_map_big) else $error("Oversize mapping not flagged");

    property p_zero_size;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        chk.req && chk.rx_size == 16'h0000 && chk.tx_size == 16'h0000
        |=> chk.detail[39:8] == 32'h0;
    endproperty
    a_zero_size: assert property (p_zero_size) else $error("Zero size gave data");
endmodule

// *** fnm_builder.sv ***
// Fault notice builder: assembles the eight-byte notice for the fieldbus master.
// Assumes alarm, check and acknowledge inputs come from logic on i_ref_clk.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
module fnm_builder
    import fnm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [REG_AW-1:0] i_reg_addr,
    input wire logic [REG_DW-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [REG_DW-1:0] o_reg_rdata,
    input wire logic i_alarm_set,
    input wire logic [15:0] i_alarm_code,
    input wire logic [7:0] i_alarm_sub,
    input wire logic i_alarm_link,
    input wire logic i_alarm_clear,
    input wire logic i_fault_reset,
    input wire logic i_check_req,
    input wire logic [15:0] i_out_addr,
    input wire logic [15:0] i_out_len,
    input wire logic [7:0] i_out_ctrl,
    input wire logic [7:0] i_out_act,
    input wire logic [15:0] i_in_addr,
    input wire logic [15:0] i_in_len,
    input wire logic [7:0] i_in_ctrl,
    input wire logic [7:0] i_in_act,
    input wire logic [15:0] i_rx_map_size,
    input wire logic [15:0] i_tx_map_size,
    output logic [NOTICE_W-1:0] o_notice_data,
    output logic o_notice_valid,
    input wire logic i_notice_ack,
    output logic [15:0] o_error_code,
    output logic [7:0] o_error_summary,
    output logic o_irq
);
    fnm_chk_if chk ();

    logic [15:0] err_code_reg;
    logic [7:0] err_sum_reg;
    logic [NOTICE_W-1:0] notice_reg;
    logic notice_valid_reg;
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] mask_reg;
    logic irq_reg;
    logic [REG_DW-1:0] rdata_reg;
    logic [15:0] code_next;
    logic [7:0] sum_next;
    logic [DETAIL_W-1:0] detail_next;
    logic [ST_W-1:0] status_set;
    logic [REG_DW-1:0] rdata_next;
    fnm_event_t ev;
    logic ev_any;

    assign chk.req = i_check_req;
    assign chk.out_addr = i_out_addr;
    assign chk.out_len = i_out_len;
    assign chk.out_ctrl = i_out_ctrl;
    assign chk.out_act = i_out_act;
    assign chk.in_addr = i_in_addr;
    assign chk.in_len = i_in_len;
    assign chk.in_ctrl = i_in_ctrl;
    assign chk.in_act = i_in_act;
    assign chk.rx_size = i_rx_map_size;
    assign chk.tx_size = i_tx_map_size;

    fnm_chan_check u_check
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .chk(chk.check_side)
    );

    // Event selection: fault reset, check verdict, alarm, then clear
    always_comb
    begin
        if (i_fault_reset)
            ev = FNM_EV_RESET;
        else if (chk.done && chk.fault)
            ev = FNM_EV_CHECK;
        else if (i_alarm_set)
            ev = FNM_EV_ALARM;
        else if (i_alarm_clear)
            ev = FNM_EV_CLEAR;
        else
            ev = FNM_EV_NONE;
        ev_any = (ev != FNM_EV_NONE);
    end

    // Content of the next notice
    always_comb
    begin
        code_next = err_code_reg;
        sum_next = err_sum_reg;
        detail_next = notice_reg[NOTICE_W-1:24];
        case (ev)
            FNM_EV_RESET:
            begin
                code_next = CODE_NONE;
                sum_next = SUM_NONE;
                detail_next = '0;
            end
            FNM_EV_CHECK:
            begin
                code_next = chk.map_fault ? CODE_MAP_FAULT : CODE_CFG_FAULT;
                sum_next = SUM_LINK;
                detail_next = chk.detail;
            end
            FNM_EV_ALARM:
            begin
                code_next = i_alarm_code;
                sum_next = i_alarm_link ? SUM_LINK : SUM_OTHER;
                detail_next = {32'h0, i_alarm_sub};
            end
            FNM_EV_CLEAR:
            begin
                detail_next = '0;
            end
            default:
            begin
                detail_next = notice_reg[NOTICE_W-1:24];
            end
        endcase
    end

    // Error code object and summary byte
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            err_code_reg <= CODE_NONE;
            err_sum_reg <= SUM_NONE;
        end
        else
        begin
            err_code_reg <= code_next;
            err_sum_reg <= sum_next;
        end
    end

    // Notice slot; a new event overwrites an unsent notice
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            notice_reg <= '0;
            notice_valid_reg <= 1'b0;
        end
        else
        begin
            if (ev_any)
            begin
                notice_reg <= {detail_next, sum_next, code_next};
                notice_valid_reg <= 1'b1;
            end
            else if (i_notice_ack)
                notice_valid_reg <= 1'b0;
        end
    end

    // Sticky events
    always_comb
    begin
        status_set = '0;
        status_set[ST_BUILT] = ev_any;
        status_set[ST_DROPPED] = ev_any && notice_valid_reg && !i_notice_ack;
        status_set[ST_CFG] = (ev == FNM_EV_CHECK);
    end

    // Status clears by writing one; a new event wins over the clear
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            status_reg <= '0;
        else if (i_reg_wr && i_reg_addr == ADDR_STATUS)
            status_reg <= (status_reg & ~i_reg_wdata[ST_W-1:0]) | status_set;
        else
            status_reg <= status_reg | status_set;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            mask_reg <= '0;
        else if (i_reg_wr && i_reg_addr == ADDR_MASK)
            mask_reg <= i_reg_wdata[ST_W-1:0];
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            irq_reg <= 1'b0;
        else
            irq_reg <= |((status_reg | status_set) & mask_reg);
    end

    // Register read decode
    always_comb
    begin
        rdata_next = '0;
        if (i_reg_addr == ADDR_ERR_SUMMARY)
            rdata_next = {24'h0, err_sum_reg};
        else if (i_reg_addr == ADDR_ERR_CODE)
            rdata_next = {16'h0, err_code_reg};
        else if (i_reg_addr == ADDR_STATUS)
            rdata_next = {{(REG_DW-ST_W){1'b0}}, status_reg};
        else if (i_reg_addr == ADDR_MASK)
            rdata_next = {{(REG_DW-ST_W){1'b0}}, mask_reg};
        else if (i_reg_addr == ADDR_NOTICE_LO)
            rdata_next = notice_reg[31:0];
        else if (i_reg_addr == ADDR_NOTICE_HI)
            rdata_next = notice_reg[63:32];
        else
            rdata_next = '0;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rdata_reg <= '0;
        else if (i_reg_rd)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= '0;
    end

    assign o_reg_rdata = rdata_reg;
    assign o_notice_data = notice_reg;
    assign o_notice_valid = notice_valid_reg;
    assign o_error_code = err_code_reg;
    assign o_error_summary = err_sum_reg;
    assign o_irq = irq_reg;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_plain_alarm;
        i_alarm_set && !i_fault_reset && !(chk.done && chk.fault);
    endsequence

    sequence s_plain_clear;
        i_alarm_clear && !i_alarm_set && !i_fault_reset && !(chk.done && chk.fault);
    endsequence

    property p_code_mirror;
        o_notice_valid |-> o_notice_data[15:0] == o_error_code;
    endproperty
    a_code_mirror: assert property (p_code_mirror) else $error("Notice code differs");

    property p_sum_mirror;
        o_notice_valid |-> o_notice_data[23:16] == o_error_summary;
    endproperty
    a_sum_mirror: assert property (p_sum_mirror) else $error("Notice summary differs");

    property p_alarm_other;
        s_plain_alarm and !i_alarm_link |=> o_error_summary == SUM_OTHER && o_notice_valid;
    endproperty
    a_alarm_other: assert property (p_alarm_other) else $error("Summary not 80h");

    property p_alarm_link;
        s_plain_alarm and i_alarm_link |=> o_error_summary == SUM_LINK;
    endproperty
    a_alarm_link: assert property (p_alarm_link) else $error("Summary not 10h");

    property p_alarm_detail;
        s_plain_alarm |=> o_notice_data[63:24] == {32'h0, $past(i_alarm_sub)}
                          && o_error_code == $past(i_alarm_code);
    endproperty
    a_alarm_detail: assert property (p_alarm_detail) else $error("Alarm detail wrong");

    property p_clear;
        s_plain_clear |=> o_notice_data[63:24] == 40'h0 && $stable(o_error_code);
    endproperty
    a_clear: assert property (p_clear) else $error("Clear kept detail");

    property p_reset;
        i_fault_reset |=> o_notice_data == 64'h0 && o_notice_valid && o_error_code == 16'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("Fault reset left data");

    property p_cfg;
        !i_fault_reset && chk.done && chk.fault && !chk.map_fault
        |=> o_error_code == CODE_CFG_FAULT && o_error_summary == SUM_LINK;
    endproperty
    a_cfg: assert property (p_cfg) else $error("Check fault code wrong");

    property p_overwrite;
        (i_alarm_set || i_alarm_clear) && o_notice_valid && !i_notice_ack
        |=> o_notice_valid && status_reg[ST_DROPPED];
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("Overwrite not recorded");

    property p_irq;
        status_set[ST_BUILT] && mask_reg[ST_BUILT] |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt missing");

    property p_sum_bits;
        (o_error_summary & ~(SUM_LINK | SUM_OTHER)) == SUM_NONE;
    endproperty
    a_sum_bits: assert property (p_sum_bits) else $error("Unsupported summary bit set");

    property p_map_fault;
        !i_fault_reset && chk.done && chk.fault && chk.map_fault
        |=> o_error_code == CODE_MAP_FAULT && o_notice_data[63:24] == {32'h0, SUB_MAP_FAULT};
    endproperty
    a_map_fault: assert property (p_map_fault) else $error("Mapping fault notice wrong");

    sequence s_check_fault;
        i_check_req ##1 !i_fault_reset && chk.fault && !chk.map_fault;
    endsequence

    property p_check_notice;
        s_check_fault |=> o_notice_valid && o_notice_data[23:0] == {SUM_LINK, CODE_CFG_FAULT};
    endproperty
    a_check_notice: assert property (p_check_notice) else $error("Check notice wrong");

    property p_sum_read;
        i_reg_rd && i_reg_addr == ADDR_ERR_SUMMARY
        |=> o_reg_rdata == {24'h0, $past(o_error_summary)};
    endproperty
    a_sum_read: assert property (p_sum_read) else $error("Summary read differs");

    property p_sum_ro;
        i_reg_wr && i_reg_addr == ADDR_ERR_SUMMARY && !ev_any |=> $stable(o_error_summary);
    endproperty
    a_sum_ro: assert property (p_sum_ro) else $error("Summary byte was written");
endmodule

// *** fnm_master_model.sv ***
// Fieldbus master stand-in: takes each fault notice and acknowledges it.
// Assumes the builder clock; i_hold stalls it, i_delay sets the wait in cycles.
`timescale 1ns/100ps
module fnm_master_model
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_valid,
    input wire logic [63:0] i_data,
    input wire logic i_hold,
    input wire logic [1:0] i_delay,
    output logic o_ack,
    output logic [63:0] o_taken,
    output logic [15:0] o_count
);
    logic [1:0] wait_reg;

    // One ack pulse per notice, then a gap so valid can fall first
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_ack <= 1'b0;
            o_taken <= 64'h0;
            o_count <= 16'h0;
            wait_reg <= 2'h0;
        end
        else if (o_ack)
            o_ack <= 1'b0;
        else if (i_valid && !i_hold)
        begin
            if (wait_reg >= i_delay)
            begin
                o_ack <= 1'b1;
                o_taken <= i_data;
                o_count <= o_count + 16'h1;
                wait_reg <= 2'h0;
            end
            else
                wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

// *** fault_notice_message_builder_bench.sv ***
// Self-checking bench of the fault notice builder with a master stand-in.
// Assumes fnm_pkg, fnm_chk_if, fnm_chan_check, fnm_builder and the model are compiled first.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module fault_notice_message_builder_bench;
    import fnm_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [15:0] addr = 16'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wr = 1'b0, rd = 1'b0, al_set = 1'b0, al_clr = 1'b0, frst = 1'b0, chk = 1'b0;
    logic link = 1'b0, hold = 1'b0;
    logic [15:0] code = 16'h0, oa = 16'h0, ol = 16'h0, ia = 16'h0, il = 16'h0;
    logic [15:0] rxs = 16'h0, txs = 16'h0, sz, n0;
    logic [7:0] sub = 8'h0, oc = 8'h0, ot = 8'h0, ic = 8'h0, it = 8'h0;
    logic [7:0] d0s [6] = '{8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0d, 8'h0e};
    logic [1:0] dly = 2'h0;
    logic [31:0] seed = 32'hcd4064d0;
    wire [63:0] notice, taken;
    wire [31:0] rdat;
    wire [15:0] ecode, tcount;
    wire [7:0] esum;
    wire nvalid, ack, irq;
    int err_total = 0;
    int cmp_count = 0;

    always #2.5 i_ref_clk = ~i_ref_clk;

    fnm_builder DUT (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
        .i_alarm_set(al_set), .i_alarm_code(code), .i_alarm_sub(sub), .i_alarm_link(link),
        .i_alarm_clear(al_clr), .i_fault_reset(frst), .i_check_req(chk), .i_out_addr(oa),
        .i_out_len(ol), .i_out_ctrl(oc), .i_out_act(ot), .i_in_addr(ia), .i_in_len(il),
        .i_in_ctrl(ic), .i_in_act(it), .i_rx_map_size(rxs), .i_tx_map_size(txs),
        .o_notice_data(notice), .o_notice_valid(nvalid), .i_notice_ack(ack),
        .o_error_code(ecode), .o_error_summary(esum), .o_irq(irq));

    fnm_master_model master (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_valid(nvalid),
        .i_data(notice), .i_hold(hold), .i_delay(dly), .o_ack(ack), .o_taken(taken),
        .o_count(tcount));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected notice: detail bytes 1-4 in r, byte 1 lowest
    function automatic logic [63:0] mk(input logic [15:0] c, input logic [7:0] s,
                                      input logic [7:0] d0, input logic [31:0] r);
        return {r, d0, s, c};
    endfunction

    // Expected detail bytes 1-4 of a channel fault
    function automatic logic [31:0] rest(input int k, input logic [15:0] size);
        if (size == 16'h0)
            return 32'h0;
        if (k == 0 || k == 3)
            return {size, size};
        if (k == 1 || k == 4)
            return 32'h2ffe1000;
        return (k == 2) ? 32'h00010024 : 32'h00010322;
    endfunction

    task finish_test();
        $display("Counts: %0d compared, %0d mismatched", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task rwr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_ref_clk);
        wr <= 1'b0;
    endtask

    task rrd(input logic [15:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_ref_clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask

    // Pulse one event: 0 alarm, 1 clear, 2 fault reset, 3 channel check
    task fire(input int e);
        @(posedge i_ref_clk);
        dly <= 2'(xs());
        al_set <= (e == 0);
        al_clr <= (e == 1);
        frst <= (e == 2);
        chk <= (e == 3);
        @(posedge i_ref_clk);
        {al_set, al_clr, frst, chk} <= 4'h0;
    endtask

    // Wait for the master to take a notice, then compare it
    task take(input logic [63:0] ex);
        logic [15:0] n;
        n = tcount;
        for (int i = 0; i < 60 && tcount == n; i++)
            @(posedge i_ref_clk);
        #1 `CHK("notice", ex, taken)
        `CHK("notice count", n + 16'h1, tcount)
    endtask

    task set_good(input logic [15:0] s);
        {oa, ol, oc, ot} <= {16'h1000, s, 8'h24, 8'h01};
        {ia, il, ic, it} <= {16'h1800, s, 8'h22, 8'h01};
        {rxs, txs} <= {s, s};
    endtask

    initial
    begin
        #(20000 * 5);
        err_total++;
        finish_test();
    end

    initial
    begin
        repeat (20) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        rrd(ADDR_ERR_SUMMARY, rdata);
        `CHK("summary reg", 32'h0, rdata)
        rrd(16'h3000, rdata);
        `CHK("unmapped reg", 32'h0, rdata)
        $display("Test done: reset values");
        {code, sub, link} <= {16'hff10, 8'h01, 1'b0};
        fire(0);
        take(mk(16'hff10, 8'h80, 8'h01, 32'h0));
        `CHK("code out", 16'hff10, ecode)
        `CHK("summary out", 8'h80, esum)
        rrd(ADDR_ERR_SUMMARY, rdata);
        `CHK("summary reg", 32'h80, rdata)
        rwr(ADDR_ERR_SUMMARY, 32'hff);
        rrd(ADDR_ERR_SUMMARY, rdata);
        `CHK("summary read only", 32'h80, rdata)
        rrd(ADDR_NOTICE_LO, rdata);
        `CHK("notice low", 32'h0180ff10, rdata)
        `CHK("irq masked", 1'b0, irq)
        rrd(ADDR_STATUS, rdata);
        `CHK("status", 32'h1, rdata)
        rwr(ADDR_MASK, 32'h1);
        @(posedge i_ref_clk);
        #1 `CHK("irq set", 1'b1, irq)
        rwr(ADDR_STATUS, 32'h1);
        @(posedge i_ref_clk);
        #1 `CHK("irq clear", 1'b0, irq)
        rwr(ADDR_MASK, 32'h0);
        $display("Test done: torque alarm and interrupt");
        for (int i = 0; i < 4; i++)
        begin
            {code, sub, link} <= {16'(xs()), 8'(xs()), i[0]};
            fire(0);
            take(mk(code, link ? SUM_LINK : SUM_OTHER, sub, 32'h0));
        end
        fire(1);
        take(mk(code, link ? SUM_LINK : SUM_OTHER, 8'h0, 32'h0));
        fire(2);
        take(64'h0);
        `CHK("code reset", 16'h0, ecode)
        $display("Test done: alarms, clear, fault reset");
        hold <= 1'b1;
        n0 = tcount;
        fire(0);
        {code, sub, link} <= {16'(xs()), 8'(xs()), 1'b0};
        fire(0);
        hold <= 1'b0;
        take(mk(code, SUM_OTHER, sub, 32'h0));
        repeat (10) @(posedge i_ref_clk);
        `CHK("notices taken", n0 + 16'h1, tcount)
        rrd(ADDR_STATUS, rdata);
        `CHK("overwrite flag", 32'h2, rdata & 32'h2)
        $display("Test done: overwrite");
        for (int j = 0; j < 4; j++)
        begin
            sz = (j == 0) ? 16'(xs() % 32 + 1) : ((j == 1) ? 16'h0 : ((j == 2) ? 16'd32 : 16'd9));
            for (int k = 0; k < 6; k++)
            begin
                set_good(sz);
                case (k)
                    0: ol <= sz + 16'h1;
                    1: oa <= 16'h1001;
                    2: ot <= 8'h00;
                    3: il <= sz + 16'h1;
                    4: ia <= 16'h3000;
                    default: ic <= 8'h21;
                endcase
                fire(3);
                take(mk(16'ha000, 8'h10, d0s[k], rest(k, sz)));
            end
        end
        set_good(16'd33);
        fire(3);
        take(mk(16'hff55, 8'h10, 8'h01, 32'h0));
        set_good(16'd20);
        txs <= 16'd40;
        fire(3);
        take(mk(16'hff55, 8'h10, 8'h01, 32'h0));
        set_good(16'd12);
        n0 = tcount;
        fire(3);
        repeat (8) @(posedge i_ref_clk);
        `CHK("no notice", n0, tcount)
        rwr(ADDR_MASK, 32'h4);
        @(posedge i_ref_clk);
        #1 `CHK("irq check", 1'b1, irq)
        rwr(ADDR_STATUS, 32'h7);
        @(posedge i_ref_clk);
        #1 `CHK("irq check clear", 1'b0, irq)
        $display("Test done: channel checks");
        finish_test();
    end
endmodule
